// *** rtl/asrad_receiver.sv ***
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
`default_nettype none
module asrad_receiver
  import asrad_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        receive_data_pin,
  output logic             receive_irq
);

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] idx);
    addr_is = (addr == idx);
  endfunction : addr_is

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic        take;
  logic        wr_take;
  logic        pop;

  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  enables_reg;
  logic [7:0]  enables_next;
  logic [7:0]  txctrl_reg;
  logic [7:0]  txctrl_next;
  logic [7:0]  baud_divisor_reg;
  logic [7:0]  baud_divisor_next;
  logic        overrun_error_bit_reg;
  logic        overrun_error_bit_next;
  logic        irq_reg;
  logic        irq_next;

  asrad_state_t state_reg;
  asrad_state_t state_next;
  logic [3:0]  sample_cnt_reg;
  logic [3:0]  sample_cnt_next;
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  bit_cnt_next;
  logic [8:0]  receive_shift_register_reg;
  logic [8:0]  receive_shift_register_next;

  logic        rx_enable;
  logic        nine_bit_receive_select;
  logic        address_detect_enable;
  logic        sample_tick;
  logic        word_done;
  logic        stop_framing_error;
  logic [7:0]  word_data;
  logic        word_ninth;
  logic        word_wanted;
  logic        push;
  logic        overrun_event;

  logic [ASRAD_FIFO_WIDTH-1:0] head_word;
  logic        fifo_empty;
  logic        fifo_full;
  logic        receive_ready_flag;
  logic [7:0]  ctrl_view;

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the access completes
  assign waitrequest = (read || write) && !ack_reg;
  assign take        = (read || write) && ack_reg;
  assign wr_take     = take && write;
  assign pop         = take && read && addr_is(address, ASRAD_IDX_DATA);

  assign receive_ready_flag = !fifo_empty;
  assign ctrl_view = {ctrl_reg[7:3],
                      head_word[9],
                      overrun_error_bit_reg,
                      head_word[8]};

  always_comb begin
    ack_next      = (read || write) && !ack_reg;
    readdata_next = readdata_reg;
    // Value latched in the wait cycle, so it stands at the completing edge
    if ((read || write) && !ack_reg) begin
      readdata_next = 32'h0000_0000;
      if (read) begin
        if (addr_is(address, ASRAD_IDX_FLAGS)) begin
          readdata_next[ASRAD_FLAG_RX_READY] = receive_ready_flag;
        end else if (addr_is(address, ASRAD_IDX_CTRL)) begin
          readdata_next[7:0] = ctrl_view;
        end else if (addr_is(address, ASRAD_IDX_DATA)) begin
          readdata_next[7:0] = head_word[7:0];
        end else if (addr_is(address, ASRAD_IDX_ENABLES)) begin
          readdata_next[7:0] = enables_reg;
        end else if (addr_is(address, ASRAD_IDX_TXCTRL)) begin
          readdata_next[7:0] = txctrl_reg | ASRAD_RST_TXCTRL;
        end else if (addr_is(address, ASRAD_IDX_BAUD)) begin
          readdata_next[7:0] = baud_divisor_reg;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg      <= ack_next;
      readdata_reg <= readdata_next;
    end
  end

  assign readdata = readdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Software registers and overrun
  always_comb begin
    ctrl_next         = ctrl_reg;
    enables_next      = enables_reg;
    txctrl_next       = txctrl_reg;
    baud_divisor_next = baud_divisor_reg;
    if (wr_take) begin
      if (addr_is(address, ASRAD_IDX_CTRL)) begin
        ctrl_next = writedata[7:0] & ASRAD_CTRL_WMASK;
      end
      if (addr_is(address, ASRAD_IDX_ENABLES)) begin
        enables_next = writedata[7:0] & ASRAD_ENABLES_MASK;
      end
      if (addr_is(address, ASRAD_IDX_TXCTRL)) begin
        txctrl_next = writedata[7:0] & ASRAD_TXC_WMASK;
      end
      if (addr_is(address, ASRAD_IDX_BAUD)) begin
        baud_divisor_next = writedata[7:0];
      end
    end
    // Receiver disabled while enable is low, so no set can race this clear
    if (!ctrl_reg[ASRAD_CTRL_CONTINUOUS_RECEIVE_ENABLE]) begin
      overrun_error_bit_next = 1'b0;
    end else if (overrun_event) begin
      overrun_error_bit_next = 1'b1;
    end else begin
      overrun_error_bit_next = overrun_error_bit_reg;
    end
    irq_next = receive_ready_flag && enables_reg[ASRAD_EN_RX_IRQ];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg              <= ASRAD_RST_CTRL;
      enables_reg           <= ASRAD_RST_ENABLES;
      txctrl_reg            <= ASRAD_RST_TXCTRL;
      baud_divisor_reg      <= ASRAD_RST_BAUD;
      overrun_error_bit_reg <= 1'b0;
      irq_reg               <= 1'b0;
    end else begin
      ctrl_reg              <= ctrl_next;
      enables_reg           <= enables_next;
      txctrl_reg            <= txctrl_next;
      baud_divisor_reg      <= baud_divisor_next;
      overrun_error_bit_reg <= overrun_error_bit_next;
      irq_reg               <= irq_next;
    end
  end

  assign receive_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Receive framing
  assign rx_enable = ctrl_reg[ASRAD_CTRL_SERIAL_PORT_ENABLE] && ctrl_reg[ASRAD_CTRL_CONTINUOUS_RECEIVE_ENABLE]
                     && !txctrl_reg[ASRAD_TXC_SYNC];
  assign nine_bit_receive_select = ctrl_reg[ASRAD_CTRL_NINE];
  assign address_detect_enable   = ctrl_reg[ASRAD_CTRL_ADDRESS_DETECT_ENABLE];

  asrad_baud_gen u_baud (
    .clk         (clk),
    .rst_n       (rst_n),
    .run         (rx_enable),
    .high_baud   (txctrl_reg[ASRAD_TXC_HIGH_BAUD]),
    .divisor     (baud_divisor_reg),
    .sample_tick (sample_tick)
  );

  always_comb begin
    state_next                  = state_reg;
    sample_cnt_next             = sample_cnt_reg;
    bit_cnt_next                = bit_cnt_reg;
    receive_shift_register_next = receive_shift_register_reg;
    word_done                   = 1'b0;
    stop_framing_error          = 1'b0;
    if (!rx_enable) begin
      state_next      = ASRAD_IDLE;
      sample_cnt_next = 4'h0;
    end else if (sample_tick) begin
      sample_cnt_next = sample_cnt_reg + 4'h1;
      case (state_reg)
        ASRAD_IDLE: begin
          sample_cnt_next = 4'h0;
          if (!receive_data_pin) begin
            state_next = ASRAD_START;
          end
        end
        ASRAD_START: begin
          if (sample_cnt_reg == ASRAD_MID_SAMPLE) begin
            // Realign so later samples land mid-bit
            sample_cnt_next = 4'h0;
            bit_cnt_next    = 4'h0;
            if (receive_data_pin) begin
              state_next = ASRAD_IDLE;
            end else begin
              state_next = ASRAD_DATA;
            end
          end
        end
        ASRAD_DATA: begin
          if (sample_cnt_reg == ASRAD_LAST_SAMPLE) begin
            receive_shift_register_next =
              {receive_data_pin, receive_shift_register_reg[8:1]};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg + 4'h1 ==
                (nine_bit_receive_select ? ASRAD_BITS_NINE : ASRAD_BITS_EIGHT)) begin
              state_next = ASRAD_STOP;
            end
          end
        end
        ASRAD_STOP: begin
          if (sample_cnt_reg == ASRAD_LAST_SAMPLE) begin
            word_done          = 1'b1;
            stop_framing_error = !receive_data_pin;
            state_next         = ASRAD_IDLE;
          end
        end
        default: begin
          state_next = ASRAD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                  <= ASRAD_IDLE;
      sample_cnt_reg             <= 4'h0;
      bit_cnt_reg                <= 4'h0;
      receive_shift_register_reg <= 9'h000;
    end else begin
      state_reg                  <= state_next;
      sample_cnt_reg             <= sample_cnt_next;
      bit_cnt_reg                <= bit_cnt_next;
      receive_shift_register_reg <= receive_shift_register_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word acceptance
  // Eight-bit words sit one place higher in the shifter
  assign word_data  = nine_bit_receive_select ? receive_shift_register_reg[7:0]
                                              : receive_shift_register_reg[8:1];
  assign word_ninth = nine_bit_receive_select && receive_shift_register_reg[8];
  // Data bytes dropped under address detect in nine-bit mode; address bytes pass
  assign word_wanted = !(nine_bit_receive_select && address_detect_enable
                         && !word_ninth);
  assign push = word_done && word_wanted && !overrun_error_bit_reg
                && !fifo_full;
  // Dropped data bytes never count as overrun
  assign overrun_event = word_done && word_wanted && !overrun_error_bit_reg
                         && fifo_full;

  asrad_rx_fifo u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (push),
    .push_word ({stop_framing_error, word_ninth, word_data}),
    .pop       (pop),
    .head_word (head_word),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

endmodule : asrad_receiver
`default_nettype wire

// *** common/asrad_pkg.sv ***
package asrad_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ASRAD_IDX_FLAGS    = 8'h0C;
  localparam logic [7:0] ASRAD_IDX_CTRL     = 8'h18;
  localparam logic [7:0] ASRAD_IDX_DATA     = 8'h1A;
  localparam logic [7:0] ASRAD_IDX_ENABLES  = 8'h8C;
  localparam logic [7:0] ASRAD_IDX_TXCTRL   = 8'h98;
  localparam logic [7:0] ASRAD_IDX_BAUD     = 8'h99;

  // Field positions
  localparam int ASRAD_FLAG_RX_READY  = 5;
  localparam int ASRAD_EN_RX_IRQ      = 5;
  localparam int ASRAD_CTRL_SERIAL_PORT_ENABLE      = 7;
  localparam int ASRAD_CTRL_NINE      = 6;
  localparam int ASRAD_CTRL_SREN      = 5;
  localparam int ASRAD_CTRL_CONTINUOUS_RECEIVE_ENABLE      = 4;
  localparam int ASRAD_CTRL_ADDRESS_DETECT_ENABLE     = 3;
  localparam int ASRAD_CTRL_FRAMING_ERROR_BIT      = 2;
  localparam int ASRAD_CTRL_OVERRUN_ERROR_BIT      = 1;
  localparam int ASRAD_CTRL_NINTH     = 0;
  localparam int ASRAD_TXC_SYNC       = 4;
  localparam int ASRAD_TXC_HIGH_BAUD  = 2;
  localparam int ASRAD_TXC_SHIFT_EMPTY = 1;

  // Values after reset and write masks
  localparam logic [7:0] ASRAD_RST_CTRL     = 8'h00;
  localparam logic [7:0] ASRAD_RST_ENABLES  = 8'h00;
  localparam logic [7:0] ASRAD_RST_TXCTRL   = 8'h02;
  localparam logic [7:0] ASRAD_RST_BAUD     = 8'h00;
  localparam logic [7:0] ASRAD_CTRL_WMASK   = 8'hF8;
  localparam logic [7:0] ASRAD_TXC_WMASK    = 8'hFD;
  localparam logic [7:0] ASRAD_ENABLES_MASK = 8'h6F;

  // Cycle counts of the receiver
  localparam logic [1:0] ASRAD_LOW_PRESCALE_LAST = 2'h3;
  localparam logic [3:0] ASRAD_MID_SAMPLE        = 4'h7;
  localparam logic [3:0] ASRAD_LAST_SAMPLE       = 4'hF;
  localparam logic [3:0] ASRAD_BITS_EIGHT        = 4'h8;
  localparam logic [3:0] ASRAD_BITS_NINE         = 4'h9;

  // Receive FIFO entry: {framing error, ninth bit, data}
  localparam int ASRAD_FIFO_WIDTH = 10;
  localparam int ASRAD_FIFO_DEPTH = 2;

  typedef enum logic [1:0] {
    ASRAD_IDLE,
    ASRAD_START,
    ASRAD_DATA,
    ASRAD_STOP
  } asrad_state_t;

endpackage : asrad_pkg

// *** rtl/asrad_baud_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module asrad_baud_gen
  import asrad_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       high_baud,
  input  wire logic [7:0] divisor,
  output logic            sample_tick
);

  logic [7:0] div_cnt_reg;
  logic [7:0] div_cnt_next;
  logic [1:0] pre_cnt_reg;
  logic [1:0] pre_cnt_next;
  logic       tick_reg;
  logic       tick_next;
  logic       base_tick;

  ////////////////////////////////////////////////////////////////////////
  // Base rate is x64 normally, x16 in high-speed; receiver wants x16
  always_comb begin
    div_cnt_next = div_cnt_reg;
    pre_cnt_next = pre_cnt_reg;
    tick_next    = 1'b0;
    base_tick    = 1'b0;
    if (!run) begin
      div_cnt_next = divisor;
      pre_cnt_next = 2'h0;
    end else if (div_cnt_reg == 8'h00) begin
      div_cnt_next = divisor;
      base_tick    = 1'b1;
    end else begin
      div_cnt_next = div_cnt_reg - 8'h01;
    end
    if (base_tick) begin
      if (high_baud) begin
        tick_next = 1'b1;
      end else if (pre_cnt_reg == ASRAD_LOW_PRESCALE_LAST) begin
        pre_cnt_next = 2'h0;
        tick_next    = 1'b1;
      end else begin
        pre_cnt_next = pre_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 8'h00;
      pre_cnt_reg <= 2'h0;
      tick_reg    <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      pre_cnt_reg <= pre_cnt_next;
      tick_reg    <= tick_next;
    end
  end

  assign sample_tick = tick_reg;

endmodule : asrad_baud_gen
`default_nettype wire

// *** rtl/asrad_rx_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module asrad_rx_fifo
  import asrad_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        push,
  input  wire logic [ASRAD_FIFO_WIDTH-1:0] push_word,
  input  wire logic                        pop,
  output logic      [ASRAD_FIFO_WIDTH-1:0] head_word,
  output logic                             empty,
  output logic                             full
);

  logic [ASRAD_FIFO_WIDTH-1:0] mem_reg  [ASRAD_FIFO_DEPTH];
  logic [ASRAD_FIFO_WIDTH-1:0] mem_next [ASRAD_FIFO_DEPTH];
  logic       wr_ptr_reg;
  logic       wr_ptr_next;
  logic       rd_ptr_reg;
  logic       rd_ptr_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic       do_push;
  logic       do_pop;

  ////////////////////////////////////////////////////////////////////////
  // Two entries: data plus its own error and ninth bit
  always_comb begin
    do_push     = push && (count_reg != 2'h2);
    do_pop      = pop && (count_reg != 2'h0);
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    for (int i = 0; i < ASRAD_FIFO_DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (do_push) begin
      mem_next[wr_ptr_reg] = push_word;
      wr_ptr_next          = ~wr_ptr_reg;
    end
    if (do_pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (do_push && !do_pop) begin
      count_next = count_reg + 2'h1;
    end else if (do_pop && !do_push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ASRAD_FIFO_DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      for (int i = 0; i < ASRAD_FIFO_DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Empty FIFO shows zero so the data register reads its reset value
  assign head_word = (count_reg == 2'h0) ? '0 : mem_reg[rd_ptr_reg];
  assign empty     = (count_reg == 2'h0);
  assign full      = (count_reg == 2'h2);

endmodule : asrad_rx_fifo
`default_nettype wire

// *** verification/asrad_receiver_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module asrad_receiver_asserts
  import asrad_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        receive_data_pin,
  input wire logic        receive_irq
);
  logic en_reg;
  logic en_next;
  logic mapped;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  assign mapped = address inside {ASRAD_IDX_FLAGS, ASRAD_IDX_CTRL, ASRAD_IDX_DATA,
                                  ASRAD_IDX_ENABLES, ASRAD_IDX_TXCTRL, ASRAD_IDX_BAUD};

  // Shadow of the irq enable, seen only through completed writes
  always_comb begin
    en_next = en_reg;
    if (write && !waitrequest && address == ASRAD_IDX_ENABLES) begin
      en_next = writedata[ASRAD_EN_RX_IRQ];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wait_cyc;
    (read || write) && waitrequest;
  endsequence

  sequence s_done(logic [7:0] a);
    read && !waitrequest && address == a;
  endsequence

  chk_wait_one: assert property (s_wait_cyc ##1 (read || write) |-> !waitrequest)
    else $error("waitrequest held past first cycle");
  chk_wait_again: assert property ((read || write) && !waitrequest |=> !(read || write) || waitrequest)
    else $error("second access skipped its wait cycle");
  chk_rdata_upper: assert property (readdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  chk_unmapped_zero: assert property (read && !waitrequest && !mapped |-> readdata[7:0] == 8'h00)
    else $error("unmapped read not zero");
  chk_flags_only: assert property (s_done(ASRAD_IDX_FLAGS) |-> (readdata[7:0] & 8'hDF) == 8'h00)
    else $error("flag register shows foreign bits");
  chk_txc_empty: assert property (s_done(ASRAD_IDX_TXCTRL) |-> readdata[1])
    else $error("shift-empty bit reads zero");
  chk_en_mask: assert property (s_done(ASRAD_IDX_ENABLES) |-> (readdata[7:0] & 8'h90) == 8'h00)
    else $error("unimplemented enable bits read set");
  chk_irq_gate: assert property (receive_irq |-> $past(en_reg))
    else $error("irq raised while disabled");
endmodule : asrad_receiver_asserts

bind asrad_receiver asrad_receiver_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .receive_data_pin(receive_data_pin), .receive_irq(receive_irq)
);
`default_nettype wire

// *** verification/asrad_serial_tx.sv ***
`timescale 1ns/10ps
`default_nettype none
module asrad_serial_tx (
  input  wire logic clk,
  output logic      line
);
  // Line idles high between frames, like the pulled-up pin
  initial line = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Start, nb data bits LSB first, stop, then two idle bits
  task automatic send(input logic [8:0] w, input int nb, input logic stopv, input int bt);
    for (int i = 0; i < nb + 4; i++) begin
      @(posedge clk);
      line <= (i == 0) ? 1'b0 : (i <= nb) ? w[i-1] : (i == nb + 1) ? stopv : 1'b1;
      repeat (bt - 1) @(posedge clk);
    end
  endtask : send

  // Short low pulse, well under half a bit
  task automatic glitch();
    @(posedge clk);
    line <= 1'b0;
    repeat (3) @(posedge clk);
    line <= 1'b1;
  endtask : glitch
endmodule : asrad_serial_tx
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb
  import asrad_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        read;
  logic        write;
  logic        waitrequest;
  logic        pin;
  logic        receive_irq;
  logic [7:0]  address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  int          failures;
  int          n_checks;

  asrad_receiver dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .receive_data_pin(pin), .receive_irq(receive_irq));
  asrad_serial_tx u_tx (.clk(clk), .line(pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    read      <= !wr;
    write     <= wr;
    address   <= a;
    writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 40) begin
      failures++;
      give_verdict();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), q, exp);
  endtask : rc

  task automatic irq_is(input logic e);
    chk("irq", {7'h00, receive_irq}, {7'h00, e});
  endtask : irq_is

  // Divisor first, async mode, then port on
  task automatic setup(input logic [7:0] ctrl);
    wr(ASRAD_IDX_BAUD, 8'h00);
    wr(ASRAD_IDX_TXCTRL, 8'h04);
    wr(ASRAD_IDX_ENABLES, 8'h20);
    wr(ASRAD_IDX_CTRL, ctrl);
  endtask : setup

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(ASRAD_IDX_FLAGS, 8'h00);
    rc(ASRAD_IDX_CTRL, 8'h00);
    rc(ASRAD_IDX_DATA, 8'h00);
    rc(ASRAD_IDX_ENABLES, 8'h00);
    rc(ASRAD_IDX_TXCTRL, 8'h02);
    rc(ASRAD_IDX_BAUD, 8'h00);
    wr(8'h10, 8'hFF);
    rc(8'h10, 8'h00);
    irq_is(1'b0);
  endtask : t_reset

  task automatic t_access();
    wr(ASRAD_IDX_ENABLES, 8'hFF);
    rc(ASRAD_IDX_ENABLES, 8'h6F);
    wr(ASRAD_IDX_FLAGS, 8'hFF);
    rc(ASRAD_IDX_FLAGS, 8'h00);
    wr(ASRAD_IDX_DATA, 8'hFF);
    rc(ASRAD_IDX_DATA, 8'h00);
    wr(ASRAD_IDX_CTRL, 8'hFF);
    rc(ASRAD_IDX_CTRL, 8'hF8);
    wr(ASRAD_IDX_CTRL, 8'h00);
    wr(ASRAD_IDX_TXCTRL, 8'h00);
    rc(ASRAD_IDX_TXCTRL, 8'h02);
    wr(ASRAD_IDX_BAUD, 8'h5A);
    rc(ASRAD_IDX_BAUD, 8'h5A);
  endtask : t_access

  task automatic t_basic();
    setup(8'h90);
    u_tx.send(9'h0A5, 8, 1'b1, 16);
    rc(ASRAD_IDX_FLAGS, 8'h20);
    irq_is(1'b1);
    rc(ASRAD_IDX_CTRL, 8'h90);
    rc(ASRAD_IDX_DATA, 8'hA5);
    repeat (3) @(posedge clk);
    irq_is(1'b0);
    wr(ASRAD_IDX_ENABLES, 8'h00);
    u_tx.send(9'h03C, 8, 1'b1, 16);
    irq_is(1'b0);
    rc(ASRAD_IDX_DATA, 8'h3C);
    wr(ASRAD_IDX_CTRL, 8'h80);
    u_tx.send(9'h077, 8, 1'b1, 16);
    rc(ASRAD_IDX_FLAGS, 8'h00);
    // Synchronous mode selected: the receiver must stay deaf
    wr(ASRAD_IDX_TXCTRL, 8'h14);
    wr(ASRAD_IDX_CTRL, 8'h90);
    u_tx.send(9'h066, 8, 1'b1, 16);
    rc(ASRAD_IDX_FLAGS, 8'h00);
  endtask : t_basic

  // Third word lands on a full FIFO; middle one has a low stop bit
  task automatic t_overrun();
    setup(8'h90);
    u_tx.send(9'h011, 8, 1'b1, 16);
    u_tx.send(9'h022, 8, 1'b0, 16);
    u_tx.send(9'h033, 8, 1'b1, 16);
    rc(ASRAD_IDX_CTRL, 8'h92);
    rc(ASRAD_IDX_DATA, 8'h11);
    rc(ASRAD_IDX_CTRL, 8'h96);
    rc(ASRAD_IDX_DATA, 8'h22);
    rc(ASRAD_IDX_FLAGS, 8'h00);
    u_tx.send(9'h044, 8, 1'b1, 16);
    rc(ASRAD_IDX_FLAGS, 8'h00);
    wr(ASRAD_IDX_CTRL, 8'h80);
    wr(ASRAD_IDX_CTRL, 8'h90);
    rc(ASRAD_IDX_CTRL, 8'h90);
    u_tx.send(9'h055, 8, 1'b1, 16);
    rc(ASRAD_IDX_DATA, 8'h55);
  endtask : t_overrun

  task automatic t_nine();
    setup(8'hD0);
    u_tx.send(9'h1A5, 9, 1'b1, 16);
    rc(ASRAD_IDX_CTRL, 8'hD1);
    rc(ASRAD_IDX_DATA, 8'hA5);
    wr(ASRAD_IDX_CTRL, 8'hD8);
    u_tx.send(9'h033, 9, 1'b1, 16);
    rc(ASRAD_IDX_FLAGS, 8'h00);
    u_tx.send(9'h1C3, 9, 1'b1, 16);
    rc(ASRAD_IDX_FLAGS, 8'h20);
    rc(ASRAD_IDX_CTRL, 8'hD9);
    rc(ASRAD_IDX_DATA, 8'hC3);
    wr(ASRAD_IDX_CTRL, 8'hD0);
    u_tx.send(9'h044, 9, 1'b1, 16);
    rc(ASRAD_IDX_CTRL, 8'hD0);
    rc(ASRAD_IDX_DATA, 8'h44);
  endtask : t_nine

  task automatic t_glitch();
    setup(8'h90);
    u_tx.glitch();
    repeat (64) @(posedge clk);
    rc(ASRAD_IDX_FLAGS, 8'h00);
  endtask : t_glitch

  // Low speed: four clocks per tick, 64 clocks per bit
  task automatic t_slow();
    setup(8'h90);
    wr(ASRAD_IDX_TXCTRL, 8'h00);
    u_tx.send(9'h05A, 8, 1'b1, 64);
    rc(ASRAD_IDX_DATA, 8'h5A);
  endtask : t_slow

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    failures  = 0;
    n_checks  = 0;
    rst_n     = 1'b0;
    read      = 1'b0;
    write     = 1'b0;
    address   = 8'h00;
    writedata = 32'h00000000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_access();
    t_basic();
    t_overrun();
    t_nine();
    t_glitch();
    t_slow();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
